// ==== timer_gate_consts.vh ====
// Constants for the timer gate control block
`ifndef TIMER_GATE_CONSTS_VH
`define TIMER_GATE_CONSTS_VH
`define OFF_GATE_CONTROL    12'h000
`define OFF_COUNT_LOW       12'h004
`define OFF_COUNT_HIGH      12'h008
`define OFF_TIMER_CONTROL   12'h00C
`define OFF_IRQ_STATUS      12'h010
`define OFF_IRQ_ENABLE      12'h014
`define OFF_IRQ_CLEAR       12'h018
`define GC_ENABLE_BIT       7
`define GC_POLARITY_BIT     6
`define GC_TOGGLE_BIT       5
`define GC_SINGLE_BIT       4
`define GC_GO_DONE_BIT      3
`define GC_STATE_BIT        2
`define GC_SOURCE_MSB       1
`define GC_SOURCE_LSB       0
`define GC_WRITE_MASK       8'hFB
`define GC_RESET            8'h00
`define TC_ON_BIT           0
`define TC_CLK_SEL_BIT      1
`define TC_ASYNC_BIT        2
`define TC_RESET            8'h00
`define COUNT_RESET         16'h0000
`define IRQ_RESET           2'h0
`define IRQ_OVERFLOW_BIT    0
`define IRQ_GATE_BIT        1
`define SRC_PIN             2'h0
`define SRC_COMPANION       2'h1
`endif

// ==== timer_gate_control.v ====
// Timer/counter with gate control, AXI4-Lite register slave
// Behaviour
// - Sixteen-bit count as high and low bytes, both software readable and writable.
// - Counter may run from the 32 kHz oscillator input or the internal clock.
// - Overflow raises interrupt; wake on overflow only with external asynchronous clock.
// - Gate enable ignored when timer off; when on, gate permits counting.
// - Polarity bit one counts on gate high, zero counts on gate low.
// - Toggle mode toggles a flip-flop on each gate rising edge, used as gate.
// - Toggle mode off keeps toggle flip-flop cleared and no toggling applied.
// - Single-pulse bit one lets single-pulse logic control gate; zero inactive.
// - Software sets go/done to arm; hardware clears it when acquisition completes.
// - Read-only bit shows present gate state regardless of gate enable.
// - Source field: 00 gate pin, 01 companion overflow, 10 and 11 reserved.
// - Power-on reset clears writable gate bits; other resets leave them unchanged.
`timescale 1ns/100ps
`include "timer_gate_consts.vh"
module timer_gate_control (
	// Clock and resets
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        por_resetn,
	// AXI4-Lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Gate and clock sources
	input  wire        gate_input_pin,
	input  wire        companion_overflow,
	input  wire        osc_32k_in,
	input  wire        sleeping,
	// Events
	output wire        irq,
	output reg         wake
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [2:0] pin_sync;
reg [2:0] osc_sync;
reg       pin_level;
reg       osc_level;
reg       osc_prev;

always @(posedge aclk) begin
	pin_sync <= {pin_sync[1:0], gate_input_pin};
	osc_sync <= {osc_sync[1:0], osc_32k_in};
	if (pin_sync[2] == pin_sync[1])
		pin_level <= pin_sync[1];
	if (osc_sync[2] == osc_sync[1])
		osc_level <= osc_sync[1];
	osc_prev <= osc_level;
end

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [7:0]  gate_control;
reg  [7:0]  timer_control;
reg  [15:0] count;
reg  [1:0]  irq_status;
reg  [1:0]  irq_enable;
reg         toggle_ff;
reg         raw_prev;
reg         pulse_active;
reg         eff_prev;

wire timer_on          = timer_control[`TC_ON_BIT];
wire clk_sel_ext       = timer_control[`TC_CLK_SEL_BIT];
wire async_mode        = timer_control[`TC_ASYNC_BIT];
wire gate_enable       = gate_control[`GC_ENABLE_BIT];
wire gate_polarity     = gate_control[`GC_POLARITY_BIT];
wire gate_toggle_mode  = gate_control[`GC_TOGGLE_BIT];
wire gate_single_pulse_mode = gate_control[`GC_SINGLE_BIT];
wire single_pulse_go_done   = gate_control[`GC_GO_DONE_BIT];
wire [1:0] gate_source_select = gate_control[`GC_SOURCE_MSB:`GC_SOURCE_LSB];

////////////////////////////////////////////////////////////////////////////////
// Gate path

reg gate_raw;
always @* begin
	case (gate_source_select)
		`SRC_PIN:       gate_raw = pin_level;
		`SRC_COMPANION: gate_raw = companion_overflow;
		default:        gate_raw = 1'b0;
	endcase
end

wire gate_pol   = gate_polarity ? gate_raw : ~gate_raw;
wire gate_rise  = gate_pol & ~raw_prev;
wire gate_tog   = gate_toggle_mode ? toggle_ff : gate_pol;
wire gate_eff   = gate_single_pulse_mode ? (pulse_active & gate_tog) : gate_tog;
wire gate_fall  = eff_prev & ~gate_tog;
wire sp_done    = gate_single_pulse_mode & pulse_active & gate_fall;
wire gate_state = gate_eff;

wire tick       = clk_sel_ext ? (osc_level & ~osc_prev) : 1'b1;
wire count_ok   = timer_on & (~gate_enable | gate_eff);
wire overflow   = count_ok & tick & (count == 16'hFFFF);

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite handshake

wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready  = wr_go;
assign s_axi_arready = rd_go;

function reg_at;
	input [11:0] addr;
	input [11:0] off;
	begin
		reg_at = (addr == off);
	end
endfunction

function wr_hit;
	input [11:0] addr;
	input [11:0] off;
	begin
		wr_hit = wr_go & reg_at(addr, off) & s_axi_wstrb[0];
	end
endfunction

wire wr_gc  = wr_hit(s_axi_awaddr, `OFF_GATE_CONTROL);
wire wr_lo  = wr_hit(s_axi_awaddr, `OFF_COUNT_LOW);
wire wr_hi  = wr_hit(s_axi_awaddr, `OFF_COUNT_HIGH);
wire wr_tc  = wr_hit(s_axi_awaddr, `OFF_TIMER_CONTROL);
wire wr_ie  = wr_hit(s_axi_awaddr, `OFF_IRQ_ENABLE);
wire wr_ic  = wr_hit(s_axi_awaddr, `OFF_IRQ_CLEAR);
wire [7:0] wd = s_axi_wdata[7:0];

////////////////////////////////////////////////////////////////////////////////
// Gate control register, reset only at power-on

always @(posedge aclk) begin
	if (!por_resetn) begin
		gate_control <= `GC_RESET;
	end else begin
		if (wr_gc) begin
			gate_control <= wd & `GC_WRITE_MASK;
			gate_control[`GC_GO_DONE_BIT] <= wd[`GC_GO_DONE_BIT] & wd[`GC_SINGLE_BIT];
		end
		if (sp_done || (!gate_single_pulse_mode && !wr_gc))
			gate_control[`GC_GO_DONE_BIT] <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Gate state machinery

always @(posedge aclk) begin
	if (!por_resetn) begin
		raw_prev     <= 1'b0;
		eff_prev     <= 1'b0;
		toggle_ff    <= 1'b0;
		pulse_active <= 1'b0;
	end else begin
		raw_prev <= gate_pol;
		eff_prev <= gate_tog;
		if (!gate_toggle_mode)
			toggle_ff <= 1'b0;
		else if (gate_rise)
			toggle_ff <= ~toggle_ff;
		if (!single_pulse_go_done)
			pulse_active <= 1'b0;
		else if (!gate_tog)
			pulse_active <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Timer control and interrupt enable

always @(posedge aclk) begin
	if (!aresetn) begin
		timer_control <= `TC_RESET;
		irq_enable    <= `IRQ_RESET;
	end else begin
		if (wr_tc)
			timer_control <= wd;
		if (wr_ie)
			irq_enable <= wd[1:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Counter and interrupt status

reg  [15:0] next_count;
reg  [1:0]  next_irq_status;
wire        next_wake = overflow & sleeping & clk_sel_ext & async_mode;

always @* begin
	next_count = count;
	if (wr_lo)
		next_count = {count[15:8], wd};
	else if (wr_hi)
		next_count = {wd, count[7:0]};
	else if (count_ok && tick)
		next_count = count + 16'h0001;
end

always @* begin
	next_irq_status = irq_status;
	if (wr_ic)
		next_irq_status = irq_status & ~wd[1:0];
	next_irq_status = next_irq_status | {sp_done, overflow};
end

always @(posedge aclk) begin
	if (!aresetn) begin
		count      <= `COUNT_RESET;
		irq_status <= `IRQ_RESET;
		wake       <= 1'b0;
	end else begin
		count      <= next_count;
		irq_status <= next_irq_status;
		wake       <= next_wake;
	end
end

assign irq = |(irq_status & irq_enable);

////////////////////////////////////////////////////////////////////////////////
// Responses and read data

reg [7:0] rd_val;
reg       rd_ok;
always @* begin
	rd_ok = 1'b1;
	if (s_axi_araddr == `OFF_GATE_CONTROL)
		rd_val = {gate_control[7:3], gate_state, gate_control[1:0]};
	else if (s_axi_araddr == `OFF_COUNT_LOW)
		rd_val = count[7:0];
	else if (s_axi_araddr == `OFF_COUNT_HIGH)
		rd_val = count[15:8];
	else if (s_axi_araddr == `OFF_TIMER_CONTROL)
		rd_val = timer_control;
	else if (s_axi_araddr == `OFF_IRQ_STATUS)
		rd_val = {6'h00, irq_status};
	else if (s_axi_araddr == `OFF_IRQ_ENABLE)
		rd_val = {6'h00, irq_enable};
	else if (s_axi_araddr == `OFF_IRQ_CLEAR)
		rd_val = 8'h00;
	else begin
		rd_val = 8'h00;
		rd_ok  = 1'b0;
	end
end

wire wr_mapped = reg_at(s_axi_awaddr, `OFF_GATE_CONTROL)
	| reg_at(s_axi_awaddr, `OFF_COUNT_LOW)
	| reg_at(s_axi_awaddr, `OFF_COUNT_HIGH)
	| reg_at(s_axi_awaddr, `OFF_TIMER_CONTROL)
	| reg_at(s_axi_awaddr, `OFF_IRQ_STATUS)
	| reg_at(s_axi_awaddr, `OFF_IRQ_ENABLE)
	| reg_at(s_axi_awaddr, `OFF_IRQ_CLEAR);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= 2'h0;
	end else if (wr_go) begin
		s_axi_bvalid <= 1'b1;
		s_axi_bresp  <= wr_mapped ? 2'h0 : 2'h2;
	end else if (s_axi_bready) begin
		s_axi_bvalid <= 1'b0;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rresp  <= 2'h0;
		s_axi_rdata  <= 32'h00000000;
	end else if (rd_go) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata  <= {24'h000000, rd_val};
		s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
	end else if (s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule // timer_gate_control

// ==== timer_gate_control_test.sv ====
// Self-checking bench for the timer gate control block
`timescale 1ns/100ps
`include "timer_gate_consts.vh"
module timer_gate_control_test;
	logic aclk, aresetn, por_resetn, awvalid, wvalid, bready, bvalid, arvalid, rready, rvalid;
	logic awready, wready, arready, irq, wake, pin, comp, osc, sleeping;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, cmd;
	logic [7:0]  lo, hi;
	logic [33:0] expq[$];
	logic [17:0] tbl [8] = '{{2'b01, 8'hC0, 8'hC4}, {2'b00, 8'hC0, 8'hC0}, {2'b00, 8'h80, 8'h84},
		{2'b01, 8'h80, 8'h80}, {2'b01, 8'h40, 8'h44}, {2'b10, 8'h41, 8'h45},
		{2'b01, 8'h41, 8'h41}, {2'b11, 8'h42, 8'h42}};
	int fails, checked, wakes;
	timer_gate_control u_timer_gate_control (.aclk(aclk), .aresetn(aresetn), .por_resetn(por_resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .gate_input_pin(pin), .companion_overflow(comp), .osc_32k_in(osc),
		.sleeping(sleeping), .irq(irq), .wake(wake));
	timer_gate_partner u_timer_gate_partner (.aclk(aclk), .cmd(cmd), .gate_input_pin(pin),
		.companion_overflow(comp));
	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	task report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input [33:0] seen, input [33:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task wr(input [11:0] a, input [7:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		{awvalid, wvalid, bready} <= 3'b111;
		do @(posedge aclk); while (!(awready && wready) && ++n < 99);
		{awvalid, wvalid} <= 2'b00;
		do @(posedge aclk); while (!bvalid && ++n < 99);
		if (n >= 99) begin fails++; report_and_stop(); end
	endtask
	task rd(input [11:0] a, input [33:0] e);
		int n;
		n = 0;
		expq.push_back(e);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do @(posedge aclk); while (!arready && ++n < 99);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid && ++n < 99);
		if (n >= 99) begin fails++; report_and_stop(); end
	endtask
	task rst(input bit por);
		aresetn <= 0;
		por_resetn <= !por;
		tick(8);
		{aresetn, por_resetn} <= 2'b11;
		tick(1);
	endtask
	task pulse();
		cmd <= 2'b01;
		tick(6);
		cmd <= 2'b00;
		tick(6);
	endtask
	always @(posedge aclk)
		if (rvalid && rready && expq.size() > 0) chk({rresp, rdata}, expq.pop_front());
	always @(posedge aclk)
		if (wake) wakes++;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, cmd, osc, sleeping} = 0;
		wakes = 0;
		{aresetn, por_resetn} = 0;
		lo = $urandom(29206);
		hi = $urandom;
		@(posedge aclk);
		rst(1);
		rd(`OFF_GATE_CONTROL, 8'h04);
		rd(12'hFFC, {2'h2, 32'h0});
		wr(`OFF_COUNT_LOW, lo);
		wr(`OFF_COUNT_HIGH, hi);
		rd(`OFF_COUNT_LOW, lo);
		rd(`OFF_COUNT_HIGH, hi);
		foreach (tbl[i]) begin
			cmd <= tbl[i][17:16];
			wr(`OFF_GATE_CONTROL, tbl[i][15:8]);
			tick(6);
			rd(`OFF_GATE_CONTROL, tbl[i][7:0]);
		end
		cmd <= 2'b00;
		tick(6);
		wr(`OFF_GATE_CONTROL, 8'hC0);
		wr(`OFF_TIMER_CONTROL, 8'h01);
		tick(20);
		rd(`OFF_COUNT_LOW, lo);
		wr(`OFF_TIMER_CONTROL, 8'h00);
		wr(`OFF_GATE_CONTROL, 8'h60);
		pulse();
		rd(`OFF_GATE_CONTROL, 8'h64);
		pulse();
		rd(`OFF_GATE_CONTROL, 8'h60);
		pulse();
		wr(`OFF_GATE_CONTROL, 8'h40);
		wr(`OFF_GATE_CONTROL, 8'h60);
		rd(`OFF_GATE_CONTROL, 8'h60);
		wr(`OFF_GATE_CONTROL, 8'h48);
		rd(`OFF_GATE_CONTROL, 8'h40);
		wr(`OFF_IRQ_ENABLE, 8'h02);
		cmd <= 2'b01;
		tick(6);
		wr(`OFF_GATE_CONTROL, 8'h58);
		rd(`OFF_GATE_CONTROL, 8'h58);
		cmd <= 2'b00;
		tick(6);
		pulse();
		rd(`OFF_GATE_CONTROL, 8'h50);
		chk(irq, 1);
		rd(`OFF_IRQ_STATUS, 8'h02);
		wr(`OFF_IRQ_ENABLE, 8'h00);
		chk(irq, 0);
		wr(`OFF_IRQ_CLEAR, 8'h02);
		rd(`OFF_IRQ_STATUS, 8'h00);
		rd(`OFF_IRQ_CLEAR, 8'h00);
		wr(`OFF_COUNT_LOW, 8'hFE);
		wr(`OFF_COUNT_HIGH, 8'hFF);
		wr(`OFF_IRQ_ENABLE, 8'h01);
		sleeping <= 1;
		wr(`OFF_TIMER_CONTROL, 8'h07);
		repeat (2) begin
			osc <= 1;
			tick(6);
			osc <= 0;
			tick(6);
		end
		chk(irq, 1);
		chk(wakes, 1);
		rd(`OFF_COUNT_LOW, 8'h00);
		rd(`OFF_COUNT_HIGH, 8'h00);
		wr(`OFF_TIMER_CONTROL, 8'h03);
		wr(`OFF_COUNT_LOW, 8'hFF);
		wr(`OFF_COUNT_HIGH, 8'hFF);
		osc <= 1;
		tick(6);
		osc <= 0;
		tick(6);
		chk(wakes, 1);
		rd(`OFF_COUNT_HIGH, 8'h00);
		rd(`OFF_IRQ_STATUS, 8'h01);
		wr(`OFF_IRQ_CLEAR, 8'h01);
		wr(`OFF_TIMER_CONTROL, 8'h00);
		sleeping <= 0;
		wr(`OFF_GATE_CONTROL, 8'hC0);
		rst(0);
		rd(`OFF_GATE_CONTROL, 8'hC0);
		rst(1);
		rd(`OFF_GATE_CONTROL, 8'h04);
		tick(2);
		report_and_stop();
	end
endmodule // timer_gate_control_test

// ==== timer_gate_partner.sv ====
// Model of the gate pin and the companion timer overflow
`timescale 1ns/100ps
module timer_gate_partner (
	// Clock and command
	input  wire       aclk,
	input  wire [1:0] cmd,
	// Gate sources
	output reg        gate_input_pin,
	output reg        companion_overflow
);
	initial {companion_overflow, gate_input_pin} = 2'b00;
	always @(posedge aclk) begin
		{companion_overflow, gate_input_pin} <= cmd;
	end
endmodule // timer_gate_partner

// ==== timer_gate_props.sv ====
// Port checker for the timer gate control block
`timescale 1ns/100ps
module timer_gate_props (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Bus
	input wire        s_axi_awvalid,
	input wire        s_axi_wvalid,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	// Events
	input wire        irq,
	input wire        wake
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
		else $error("read not answered");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	chk_slverr_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	chk_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !wake)
		else $error("outputs active after reset");
	chk_wake_pulse: assert property (wake |=> !wake)
		else $error("wake longer than a cycle");
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (irq);
endmodule // timer_gate_props
bind timer_gate_control timer_gate_props u_timer_gate_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.irq(irq), .wake(wake));
